// ---- sim/safety_ctrl_model.sv ----
// Purpose: Outside safety controller driving both inhibit channels
// Assumes: Commands change at the falling edge of the system clock
// Notes:   Channels are driven independently, never from one source
`timescale 1ns/1ps
module safety_ctrl_model (
  input  wire logic want_first,
  input  wire logic want_second,
  input  wire logic relay_pos,
  output logic      inhibit_channel_first,
  output logic      inhibit_channel_second,
  output logic      relay_seen
);
  // ==========================================================
  // Channel drivers
  assign inhibit_channel_first  = want_first;
  assign inhibit_channel_second = want_second;

  // ==========================================================
  // Status relay
  // indication only
  assign relay_seen = relay_pos;
endmodule

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the torque-off monitor
// Assumes: Short filter and fault counts for simulation
// Notes:   Delays are checked as ranges from the filter window upward and around the fault count
`timescale 1ns/1ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  failures++; $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module tb;
  import torque_off_pkg::*;
  localparam logic [FLT_W-1:0]   F = 20'h8;
  localparam logic [FAULT_W-1:0] T = 28'hc8;
  logic clk, nrst, want_first, want_second, ch_a, ch_b, relay_seen;
  logic drive_enable, pos, neg, fault_latched, channel_disagree;
  int   failures, samples_checked, n;

  safety_ctrl_model i_safety_ctrl_model (
    .want_first             (want_first),
    .want_second            (want_second),
    .relay_pos              (pos),
    .inhibit_channel_first  (ch_a),
    .inhibit_channel_second (ch_b),
    .relay_seen             (relay_seen)
  );
  torque_off_monitor #(.FILTER_CYC(F), .FAULT_CYC(T)) i_torque_off_monitor (
    .clk                      (clk),
    .nrst                     (nrst),
    .inhibit_channel_first    (ch_a),
    .inhibit_channel_second   (ch_b),
    .drive_enable             (drive_enable),
    .safe_state_indicator_pos (pos),
    .safe_state_indicator_neg (neg),
    .fault_latched            (fault_latched),
    .channel_disagree         (channel_disagree)
  );

  // ==========================================================
  // Helpers
  task automatic cyc(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic set_ch(input logic a, input logic b);
    @(negedge clk);
    want_first = a;
    want_second = b;
  endtask
  task automatic wait_en(input logic v, output int k);
    k = 0;
    while (drive_enable !== v && k < 100) begin
      cyc(1);
      k++;
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    `CHK("en_rst", 1'b0, drive_enable)
    `CHK("neg_rst", 1'b1, neg)
    `CHK("flt_rst", 1'b0, fault_latched)
  endtask
  task automatic t_settle();
    cyc(F + 10);
    `CHK("pos_init", 1'b1, pos)
    `CHK("en_init", 1'b0, drive_enable)
  endtask
  task automatic t_run();
    set_ch(1'b1, 1'b1);
    wait_en(1'b1, n);
    `CHK("run_delay", 1'b1, (n >= F && n <= F + 8))
    `CHK("pos_run", 1'b0, pos)
    `CHK("neg_run", 1'b1, neg)
  endtask
  task automatic t_pulse();
    set_ch(1'b0, 1'b1);
    repeat (3) begin
      cyc(1);
      `CHK("en_in_pulse", 1'b1, drive_enable)
    end
    set_ch(1'b1, 1'b1);
    repeat (F + 10) begin
      cyc(1);
      `CHK("en_pulse", 1'b1, drive_enable)
    end
    `CHK("dis_pulse", 1'b0, channel_disagree)
  endtask
  task automatic t_one_low(input logic a, input logic b);
    set_ch(a, b);
    wait_en(1'b0, n);
    `CHK("stop_delay", 1'b1, (n >= F && n <= F + 8))
    `CHK("dis_one", 1'b1, channel_disagree)
    `CHK("pos_one", 1'b0, pos)
    cyc(T / 2);
    `CHK("flt_short", 1'b0, fault_latched)
    t_run();
  endtask
  task automatic t_safe();
    set_ch(1'b0, 1'b0);
    cyc(F + 10);
    `CHK("en_safe", 1'b0, drive_enable)
    `CHK("pos_safe", 1'b1, pos)
    `CHK("neg_safe", 1'b0, neg)
    `CHK("relay_safe", 1'b1, relay_seen)
  endtask
  task automatic t_fault();
    set_ch(1'b1, 1'b0);
    n = 0;
    while (channel_disagree !== 1'b1 && n < 100) begin
      cyc(1);
      n++;
    end
    n = 0;
    while (fault_latched !== 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    `CHK("flt_time", 1'b1, (n >= T - 2 && n <= T + 3))
    set_ch(1'b1, 1'b1);
    cyc(F + 10);
    `CHK("flt_hold", 1'b1, fault_latched)
    `CHK("en_flt", 1'b0, drive_enable)
    `CHK("pos_flt", 1'b0, pos)
    `CHK("relay_flt", 1'b0, relay_seen)
    nrst = 1'b0;
    want_second = 1'b0;
    cyc(3);
    nrst = 1'b1;
    cyc(1);
    `CHK("flt_clr", 1'b0, fault_latched)
    `CHK("en_clr", 1'b0, drive_enable)
    cyc(F + 10);
    `CHK("dis_init", 1'b1, channel_disagree)
    `CHK("pos_init_split", 1'b0, pos)
    set_ch(1'b1, 1'b1);
    cyc(F + 10);
    `CHK("en_rearm", 1'b1, drive_enable)
  endtask

  // ==========================================================
  // Clock, reset and sequence
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    nrst = 1'b0;
    want_first = 1'b0;
    want_second = 1'b0;
    failures = 0;
    samples_checked = 0;
    cyc(4);
    t_reset();
    nrst = 1'b1;
    cyc(1);
    t_reset();
    t_settle();
    t_run();
    t_pulse();
    t_one_low(1'b0, 1'b1);
    t_one_low(1'b1, 1'b0);
    t_safe();
    t_fault();
    finish_test();
  end
  initial begin
    repeat (5000) @(posedge clk);
    failures++;
    finish_test();
  end
endmodule

// ---- src/inhibit_filter.sv ----
// Purpose: Synchronise one inhibit input and reject short pulses
// Assumes: Input may be asynchronous to clk; floating reads as low
// Notes:   Output level changes only after a full stable window
`timescale 1ns/1ps
module inhibit_filter #(
  parameter logic [torque_off_pkg::FLT_W-1:0] FILTER_CYC =
    torque_off_pkg::FILTER_CYC_DEF
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic raw_in,
  output logic      level,
  output logic      settled
);
  import torque_off_pkg::*;

  flt_reg_t flt_ff;
  flt_reg_t nxt_flt;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_flt       = flt_ff;
    nxt_flt.sync1 = raw_in;
    nxt_flt.sync2 = flt_ff.sync1;
    nxt_flt.prev  = flt_ff.sync2;
    // Stability counter restarts on any edge
    if (flt_ff.sync2 != flt_ff.prev) begin
      nxt_flt.cnt = {FLT_W{1'h0}};
    end else if (flt_ff.cnt != FILTER_CYC) begin
      nxt_flt.cnt = flt_ff.cnt + FLT_W'(1);
    end
    if (flt_ff.cnt == FILTER_CYC) begin
      nxt_flt.level   = flt_ff.prev;
      nxt_flt.settled = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      flt_ff <= FLT_RST;
    end else begin
      flt_ff <= nxt_flt;
    end
  end

  assign level   = flt_ff.level;
  assign settled = flt_ff.settled;

  // ==========================================================
  // Checks
  a_level_after_window: assert property (
    @(posedge clk) disable iff (!nrst)
    (level != $past(level)) |-> ($past(flt_ff.cnt) == FILTER_CYC))
    else $error("Filtered level moved before stable window");

  a_settled_sticky: assert property (
    @(posedge clk) disable iff (!nrst)
    settled |=> settled)
    else $error("Settled flag dropped");

endmodule

// ---- src/torque_off_monitor.sv ----
// Purpose: Dual-channel torque-off monitor with latched channel fault
// Assumes: Inputs synchronous after filter; nrst only on power cycle
// Notes:   No input can disable the monitor; outputs are registered
`timescale 1ns/1ps

module torque_off_monitor #(
  parameter logic [torque_off_pkg::FLT_W-1:0]   FILTER_CYC =
    torque_off_pkg::FILTER_CYC_DEF,
  parameter logic [torque_off_pkg::FAULT_W-1:0] FAULT_CYC  =
    torque_off_pkg::FAULT_CYC_DEF
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic inhibit_channel_first,
  input  wire logic inhibit_channel_second,
  output logic      drive_enable,
  output logic      safe_state_indicator_pos,
  output logic      safe_state_indicator_neg,
  output logic      fault_latched,
  output logic      channel_disagree
);
  import torque_off_pkg::*;

  logic     lvl_a;
  logic     lvl_b;
  logic     set_a;
  logic     set_b;
  logic     ready;
  logic     both_hi;
  logic     both_lo;
  logic     split;
  mon_reg_t mon_ff;
  mon_reg_t nxt_mon;

  // ==========================================================
  // Input filters
  inhibit_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_filt_first (
    .clk     (clk),
    .nrst    (nrst),
    .raw_in  (inhibit_channel_first),
    .level   (lvl_a),
    .settled (set_a)
  );

  inhibit_filter #(
    .FILTER_CYC (FILTER_CYC)
  ) u_filt_second (
    .clk     (clk),
    .nrst    (nrst),
    .raw_in  (inhibit_channel_second),
    .level   (lvl_b),
    .settled (set_b)
  );

  // ==========================================================
  // Channel decode
  assign ready   = set_a & set_b;
  assign both_hi = lvl_a & lvl_b;
  assign both_lo = ~lvl_a & ~lvl_b;
  assign split   = lvl_a ^ lvl_b;

  // ==========================================================
  // Next state
  always_comb begin
    nxt_mon = mon_ff;
    case (mon_ff.st)
      ST_INIT: begin
        // Hold inhibited until both filters settled
        if (ready) begin
          if (both_lo) begin
            nxt_mon.st = ST_SAFE;
          end else if (both_hi) begin
            nxt_mon.st = ST_RUN;
          end else begin
            nxt_mon.st = ST_SPLIT;
          end
        end
      end
      ST_SAFE, ST_RUN, ST_SPLIT: begin
        if (split) begin
          nxt_mon.dis_cnt = mon_ff.dis_cnt + FAULT_W'(1);
        end else begin
          nxt_mon.dis_cnt = {FAULT_W{1'h0}};
        end
        if (split && (mon_ff.dis_cnt == FAULT_CYC - FAULT_W'(1))) begin
          nxt_mon.st = ST_FAULT;
        end else if (both_hi) begin
          nxt_mon.st = ST_RUN;
        end else if (both_lo) begin
          nxt_mon.st = ST_SAFE;
        end else begin
          nxt_mon.st = ST_SPLIT;
        end
      end
      ST_FAULT: begin
        nxt_mon.st = ST_FAULT;
      end
      default: begin
        nxt_mon.st = ST_FAULT;
      end
    endcase

    nxt_mon.run     = (nxt_mon.st == ST_RUN);
    nxt_mon.ind_pos = (nxt_mon.st == ST_SAFE);
    nxt_mon.ind_neg = ~(nxt_mon.st == ST_SAFE);
    nxt_mon.fault   = (nxt_mon.st == ST_FAULT);
    nxt_mon.split   = (nxt_mon.st == ST_SPLIT);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mon_ff <= MON_RST;
    end else begin
      mon_ff <= nxt_mon;
    end
  end

  assign drive_enable             = mon_ff.run;
  assign safe_state_indicator_pos = mon_ff.ind_pos;
  assign safe_state_indicator_neg = mon_ff.ind_neg;
  assign fault_latched            = mon_ff.fault;
  assign channel_disagree         = mon_ff.split;

  // ==========================================================
  // Checks
  a_run_needs_both: assert property (
    @(posedge clk) disable iff (!nrst)
    drive_enable |-> ($past(lvl_a) && $past(lvl_b)))
    else $error("Drive enabled without both channels high");

  a_first_low_stops: assert property (
    @(posedge clk) disable iff (!nrst)
    !lvl_a |=> !drive_enable)
    else $error("Drive enabled with first channel low");

  a_second_low_stops: assert property (
    @(posedge clk) disable iff (!nrst)
    !lvl_b |=> !drive_enable)
    else $error("Drive enabled with second channel low");

  a_safe_relay_on: assert property (
    @(posedge clk) disable iff (!nrst)
    (ready && both_lo && !fault_latched) |=>
      (safe_state_indicator_pos && !safe_state_indicator_neg))
    else $error("Status relay open in safe state");

  a_relay_pair: assert property (
    @(posedge clk) disable iff (!nrst)
    safe_state_indicator_pos == !safe_state_indicator_neg)
    else $error("Status relay terminals inconsistent");

  a_timer_clears: assert property (
    @(posedge clk) disable iff (!nrst)
    (!split && mon_ff.st != ST_FAULT && mon_ff.st != ST_INIT) |=>
      (mon_ff.dis_cnt == {FAULT_W{1'h0}}))
    else $error("Disagreement timer not cleared");

  a_no_early_fault: assert property (
    @(posedge clk) disable iff (!nrst)
    $rose(fault_latched) |->
      ($past(mon_ff.dis_cnt) == FAULT_CYC - FAULT_W'(1)))
    else $error("Fault declared before disagreement time");

  a_late_fault: assert property (
    @(posedge clk) disable iff (!nrst)
    (split && mon_ff.dis_cnt == FAULT_CYC - FAULT_W'(1)) |=>
      fault_latched)
    else $error("Fault missed after disagreement time");

  a_fault_sticky: assert property (
    @(posedge clk) disable iff (!nrst)
    fault_latched |=>
      (fault_latched && !drive_enable && !safe_state_indicator_pos))
    else $error("Fault latch released or outputs wrong");

  a_one_high_trip: assert property (
    @(posedge clk) disable iff (!nrst)
    split |=> (!drive_enable && !safe_state_indicator_pos))
    else $error("Single channel high not tripped");

  a_init_inhibit: assert property (
    @(posedge clk) disable iff (!nrst)
    !ready |=> (!drive_enable && !safe_state_indicator_pos))
    else $error("Outputs active before inputs settled");

  a_run_relay_open: assert property (
    @(posedge clk) disable iff (!nrst)
    drive_enable |-> !safe_state_indicator_pos)
    else $error("Status relay closed while drive enabled");

  a_fault_outputs: assert property (
    @(posedge clk) disable iff (!nrst)
    fault_latched |->
      (!channel_disagree && !drive_enable && safe_state_indicator_neg))
    else $error("Fault state outputs inconsistent");

endmodule

// ---- src/torque_off_pkg.sv ----
// Purpose: Shared constants and state types for the torque-off monitor
// Assumes: 100 MHz system clock
// Notes:   Times are kept in their own unit; cycle counts derive from them
package torque_off_pkg;

  // ==========================================================
  // Clock
  localparam int unsigned CLK_FREQ_HZ = 100_000_000;
  localparam int unsigned CLK_PER_US  = CLK_FREQ_HZ / 1_000_000;
  localparam int unsigned CLK_PER_MS  = CLK_FREQ_HZ / 1_000;

  // ==========================================================
  // Input filter timing
  // Pulses narrower than this are ignored
  localparam int unsigned PULSE_REJECT_US = 2000;
  // Chosen settle time: above the reject width, below response limit
  localparam int unsigned FILTER_TIME_US  = 6000;
  localparam int unsigned RESPONSE_MAX_US = 10000;
  localparam int unsigned FLT_W           = 20;
  localparam logic [FLT_W-1:0] FILTER_CYC_DEF =
    FLT_W'(FILTER_TIME_US * CLK_PER_US);

  // ==========================================================
  // Disagreement timing
  localparam int unsigned FAULT_MIN_MS = 1600;
  localparam int unsigned FAULT_NOM_MS = 2300;
  localparam int unsigned FAULT_MAX_MS = 3000;
  localparam int unsigned FAULT_W      = 28;
  localparam logic [FAULT_W-1:0] FAULT_CYC_DEF =
    FAULT_W'(FAULT_NOM_MS * CLK_PER_MS);

  // ==========================================================
  // Filter state
  typedef struct packed {
    logic             sync1;
    logic             sync2;
    logic             prev;
    logic [FLT_W-1:0] cnt;
    logic             level;
    logic             settled;
  } flt_reg_t;

  localparam flt_reg_t FLT_RST = '{
    sync1:   1'h0,
    sync2:   1'h0,
    prev:    1'h0,
    cnt:     {FLT_W{1'h0}},
    level:   1'h0,
    settled: 1'h0
  };

  // ==========================================================
  // Monitor state
  typedef enum logic [2:0] {
    ST_INIT,
    ST_SAFE,
    ST_RUN,
    ST_SPLIT,
    ST_FAULT
  } mon_state_t;

  typedef struct packed {
    mon_state_t         st;
    logic [FAULT_W-1:0] dis_cnt;
    logic               run;
    logic               ind_pos;
    logic               ind_neg;
    logic               fault;
    logic               split;
  } mon_reg_t;

  localparam mon_reg_t MON_RST = '{
    st:      ST_INIT,
    dis_cnt: {FAULT_W{1'h0}},
    run:     1'h0,
    ind_pos: 1'h0,
    ind_neg: 1'h1,
    fault:   1'h0,
    split:   1'h0
  };

endpackage
